// ===== bench/asri_line_src.sv
// Purpose: Remote transmitter model driving the receive line.
// Assumes: One sample tick per aclk cycle, so a bit lasts BIT_CLKS cycles.
// Notes:   A glitch mask inverts chosen samples of one bit of the frame.
`timescale 1ns/10ps
module asri_line_src #(
  parameter int BIT_CLKS = 16
) (
  input  wire  aclk,
  output logic line
);
  initial line = 1'b1;

  task automatic send(input [8:0] d, input int nb, input logic stp,
                      input int gb, input [15:0] gm);
    logic b;
    for (int k = 0; k < nb + 2; k++) begin
      b = (k == 0) ? 1'b0 : (k <= nb) ? d[k-1] : stp;
      for (int s = 0; s < BIT_CLKS; s++) begin
        @(posedge aclk);
        line <= b ^ (k == gb && gm[s]);
      end
    end
    // The idle gap gives the receiver three 1 samples before a start.
    repeat (2 * BIT_CLKS) begin
      @(posedge aclk);
      line <= 1'b1;
    end
  endtask
endmodule // asri_line_src

// ===== bench/asri_rx_chk.sv
// Purpose: Port-level checks of the serial receiver block.
// Assumes: Sees only the top module ports.
// Notes:   Bound into every instance of the receiver.
`timescale 1ns/10ps
module asri_rx_chk (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [7:0]  s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        cpu_wait_mode,
  input wire        cpu_stop_mode,
  input wire        irq_rx_r,
  input wire        irq_err_r
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  wire w_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid
                && s_axi_wready;
  wire r_take = s_axi_arvalid && s_axi_arready;
  // Stop mode with no bus traffic must leave the receiver frozen.
  wire quiet  = cpu_stop_mode && !s_axi_awvalid && !s_axi_wvalid
                && !s_axi_arvalid && !s_axi_bvalid && !s_axi_rvalid;

  // Both halves are held for one cycle before the response is raised.
  property p_b_after_take;
    w_take |=> (!s_axi_awready && !s_axi_wready) ##1 s_axi_bvalid;
  endproperty
  a_b_after_take: assert property (p_b_after_take)
    else $error("write response not two cycles after take");
  property p_b_done;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready;
  endproperty
  a_b_done: assert property (p_b_done)
    else $error("write response not released");
  property p_r_next;
    r_take |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_r_next: assert property (p_r_next)
    else $error("read data not one cycle after take");
  property p_r_done;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
  endproperty
  a_r_done: assert property (p_r_done)
    else $error("read data not released");
  property p_unmapped;
    r_take && s_axi_araddr > 8'h10 |=> s_axi_rresp == 2'h2
      && s_axi_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not refused");
  property p_wait_rd;
    r_take && cpu_wait_mode |=> s_axi_rresp == 2'h2;
  endproperty
  a_wait_rd: assert property (p_wait_rd)
    else $error("read in wait mode not refused");
  property p_wait_wr;
    w_take ##1 cpu_wait_mode |=> s_axi_bresp == 2'h2;
  endproperty
  a_wait_wr: assert property (p_wait_wr)
    else $error("write in wait mode not refused");
  property p_stop_frozen;
    quiet [*3] |=> $stable(irq_rx_r) && $stable(irq_err_r);
  endproperty
  a_stop_frozen: assert property (p_stop_frozen)
    else $error("receiver interrupts moved in stop mode");
endmodule // asri_rx_chk

bind asri_rx asri_rx_chk u_chk (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .cpu_wait_mode, .cpu_stop_mode, .irq_rx_r, .irq_err_r);

// ===== bench/tb.sv
// Purpose: Self-checking bench of the serial receiver block.
// Assumes: Sample divisor left at its reset value, so a bit is 16 cycles.
// Notes:   Bus results are queued by the drivers and checked by a monitor.
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
  bad_count++; $display("unexpected at %0t: got %h expected %h", \
  $time, g, e); end end
module tb;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, serial_in_pin;
  logic        tx_load_pulse, tx_buf_write_pulse, tx_shift_empty;
  logic        tx_break_idle_busy, cpu_wait_mode, cpu_stop_mode;
  logic        irq_tx_r, irq_rx_r, irq_err_r;
  int          bad_count, total_checks, seed;
  logic [65:0] rq[$];
  logic [1:0]  bq[$];
  logic [8:0]  c, c2;
  logic [15:0] gtab[3] = '{16'h0100, 16'h0018, 16'h0300};

  asri_rx dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serial_in_pin,
    .tx_load_pulse, .tx_buf_write_pulse, .tx_shift_empty,
    .tx_break_idle_busy, .cpu_wait_mode, .cpu_stop_mode, .irq_tx_r,
    .irq_rx_r, .irq_err_r);
  asri_line_src src (.aclk(aclk), .line(serial_in_pin));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic wr(input [7:0] a, input [31:0] d, input [1:0] rs);
    bq.push_back(rs);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  // Only the bits set in m are compared.
  task automatic rd(input [7:0] a, input [31:0] ex, m, input [1:0] rs);
    rq.push_back({rs, m, ex & m});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  task automatic clr;
    rd(8'h08, 32'h0, 32'h0, 2'h0);
    rd(8'h0c, 32'h0, 32'h0, 2'h0);
  endtask

  task automatic rx(input [8:0] d, input int nb, input logic stp,
                    input int gb, input [15:0] gm);
    src.send(d, nb, stp, gb, gm);
    repeat (4) @(posedge aclk);
  endtask

  always @(posedge aclk) begin
    logic [65:0] e;
    logic [1:0]  eb;
    if (s_axi_rvalid && s_axi_rready && rq.size() > 0) begin
      e = rq.pop_front();
      `CHK(s_axi_rresp, e[65:64])
      `CHK(s_axi_rdata & e[63:32], e[31:0])
    end
    // Pop once: the macro names its expected value twice.
    if (s_axi_bvalid && s_axi_bready && bq.size() > 0) begin
      eb = bq.pop_front();
      `CHK(s_axi_bresp, eb)
    end
  end

  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    test_done;
  end

  initial begin
    seed = 32'hdfd5;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, tx_load_pulse, tx_buf_write_pulse} = '0;
    {tx_break_idle_busy, cpu_wait_mode, cpu_stop_mode} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    tx_shift_empty = 1'b1;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, 32'h0, '1, 2'h0);
    rd(8'h04, 32'h0, '1, 2'h0);
    rd(8'h08, 32'hc0, '1, 2'h0);
    rd(8'h10, 32'h1, '1, 2'h0);
    rd(8'h14, 32'h0, '1, 2'h2);
    wr(8'h08, 32'hff, 2'h2);
    wr(8'h00, 32'h1, 2'h0);
    wr(8'h04, 32'ha2, 2'h0);
    c = 9'($random(seed)) & 9'h0ff;
    rx(c, 8, 1'b1, -1, 16'h0);
    `CHK(irq_rx_r, 1'b1)
    rd(8'h08, 32'he0, 32'hef, 2'h0);
    rd(8'h0c, {c[7], c[7:0]}, 32'h1ff, 2'h0);
    wr(8'h00, 32'h3, 2'h0);
    c = 9'($random(seed)) | 9'h100;
    rx(c, 9, 1'b1, -1, 16'h0);
    rd(8'h08, 32'he0, 32'hef, 2'h0);
    rd(8'h0c, c, 32'h1ff, 2'h0);
    // Same character under even and then odd parity: one of them flags.
    wr(8'h00, 32'h21, 2'h0);
    c = 9'($random(seed)) & 9'h0ff;
    rx(c, 8, 1'b1, -1, 16'h0);
    rd(8'h08, 32'he0 | {31'h0, ^c[7:0]}, 32'hef, 2'h0);
    rd(8'h0c, c, 32'h0ff, 2'h0);
    wr(8'h00, 32'h61, 2'h0);
    rx(c, 8, 1'b1, -1, 16'h0);
    rd(8'h08, 32'he0 | {31'h0, ~^c[7:0]}, 32'hef, 2'h0);
    rd(8'h0c, c, 32'h0ff, 2'h0);
    wr(8'h00, 32'h1, 2'h0);
    // A single-sample glitch in a data bit and two-sample glitches in the start bit.
    for (int i = 0; i < 3; i++) begin
      c = 9'($random(seed)) & 9'h0ff;
      rx(c, 8, 1'b1, (i == 0) ? 3 : 0, gtab[i]);
      rd(8'h08, 32'he4, 32'hef, 2'h0);
      rd(8'h0c, c, 32'h0ff, 2'h0);
    end
    rx(9'h0ff, 8, 1'b1, 0, 16'hfffc);
    rd(8'h08, 32'hc0, 32'hef, 2'h0);
    c = 9'($random(seed)) & 9'h0ff;
    rx(c, 8, 1'b0, -1, 16'h0);
    `CHK(irq_err_r, 1'b1)
    rd(8'h08, 32'he2, 32'hef, 2'h0);
    rd(8'h0c, c, 32'h0ff, 2'h0);
    rx(9'h0, 8, 1'b0, -1, 16'h0);
    rd(8'h08, 32'he2, 32'hef, 2'h0);
    rd(8'h0c, 32'h0, 32'h1ff, 2'h0);
    c = 9'($random(seed)) & 9'h0ff;
    c2 = 9'($random(seed)) & 9'h0ff;
    rx(c, 8, 1'b1, -1, 16'h0);
    rx(c2, 8, 1'b1, -1, 16'h0);
    rd(8'h08, 32'he8, 32'hef, 2'h0);
    rd(8'h0c, c, 32'h0ff, 2'h0);
    wr(8'h00, 32'h15, 2'h0);
    rx(9'h035, 8, 1'b1, -1, 16'h0);
    `CHK(irq_rx_r, 1'b0)
    rd(8'h08, 32'hc0, 32'hef, 2'h0);
    rx(9'h0b5, 8, 1'b1, -1, 16'h0);
    `CHK(irq_rx_r, 1'b1)
    rd(8'h00, 32'h05, 32'h7f, 2'h0);
    // Back to standby with the full flag still up: the request must drop.
    wr(8'h00, 32'h15, 2'h0);
    rd(8'h08, 32'he0, 32'hef, 2'h0);
    `CHK(irq_rx_r, 1'b0)
    rd(8'h0c, 32'hb5, 32'h0ff, 2'h0);
    repeat (200) @(posedge aclk);
    clr;
    wr(8'h00, 32'h11, 2'h0);
    repeat (12 * 16) @(posedge aclk);
    rd(8'h00, 32'h01, 32'h7f, 2'h0);
    rd(8'h08, 32'hc0, 32'hff, 2'h0);
    rx(9'h0ff, 8, 1'b1, -1, 16'h0);
    rd(8'h08, 32'hf0, 32'hff, 2'h0);
    clr;
    wr(8'h00, 32'h09, 2'h0);
    rx(9'h0ff, 8, 1'b1, -1, 16'h0);
    rd(8'h08, 32'he0, 32'hff, 2'h0);
    clr;
    repeat (10 * 16) @(posedge aclk);
    rd(8'h08, 32'hd0, 32'hff, 2'h0);
    @(posedge aclk);
    tx_buf_write_pulse <= 1'b1;
    tx_shift_empty <= 1'b0;
    @(posedge aclk);
    tx_buf_write_pulse <= 1'b0;
    rd(8'h08, 32'h0, 32'hc0, 2'h0);
    `CHK(irq_tx_r, 1'b0)
    @(posedge aclk);
    tx_load_pulse <= 1'b1;
    tx_break_idle_busy <= 1'b1;
    @(posedge aclk);
    tx_load_pulse <= 1'b0;
    tx_shift_empty <= 1'b1;
    rd(8'h08, 32'h80, 32'hc0, 2'h0);
    `CHK(irq_tx_r, 1'b1)
    @(posedge aclk);
    tx_break_idle_busy <= 1'b0;
    rd(8'h08, 32'hc0, 32'hc0, 2'h0);
    @(posedge aclk);
    cpu_wait_mode <= 1'b1;
    rd(8'h04, 32'h0, '1, 2'h2);
    wr(8'h04, 32'h0, 2'h2);
    @(posedge aclk);
    cpu_wait_mode <= 1'b0;
    rd(8'h04, 32'ha2, '1, 2'h0);
    @(posedge aclk);
    cpu_stop_mode <= 1'b1;
    rx(9'($random(seed)) & 9'h0ff, 8, 1'b1, -1, 16'h0);
    @(posedge aclk);
    cpu_stop_mode <= 1'b0;
    rd(8'h08, 32'h0, 32'h20, 2'h0);
    rd(8'h00, 32'h09, 32'h7f, 2'h0);
    test_done;
  end
endmodule // tb

// ===== core/asri_map.vh
// Purpose: Register map, field positions, reset values and sample points.
// Assumes: Included by the receiver module asri_rx only.
// Notes:   Definitions only.
`ifndef ASRI_MAP_VH
`define ASRI_MAP_VH

`define ASRI_OFF_CTRL    8'h00
`define ASRI_OFF_INTEN   8'h04
`define ASRI_OFF_STATUS  8'h08
`define ASRI_OFF_DATA    8'h0c
`define ASRI_OFF_BAUD    8'h10

`define ASRI_CTRL_EN      0
`define ASRI_CTRL_LEN9    1
`define ASRI_CTRL_WAKEADR 2
`define ASRI_CTRL_IDLE_COUNT_START_SEL    3
`define ASRI_CTRL_STBY    4
`define ASRI_CTRL_PAREN   5
`define ASRI_CTRL_PARODD  6

`define ASRI_ST_TXE    7
`define ASRI_ST_TDONE  6
`define ASRI_ST_FULL   5
`define ASRI_ST_IDLE   4
`define ASRI_ST_OVR    3
`define ASRI_ST_NOISE  2
`define ASRI_ST_FRM    1
`define ASRI_ST_PAR    0

`define ASRI_CTRL_RST   7'h00
`define ASRI_INTEN_RST  8'h00
`define ASRI_BAUD_RST   16'h0001
`define ASRI_RESP_OK    2'h0
`define ASRI_RESP_ERR   2'h2

`define ASRI_RT_LAST    5'h10
`define ASRI_RT_VER_A   5'h03
`define ASRI_RT_VER_B   5'h05
`define ASRI_RT_VER_C   5'h07
`define ASRI_RT_DAT_A   5'h08
`define ASRI_RT_DAT_B   5'h09
`define ASRI_RT_DAT_C   5'h0a
`define ASRI_RT_SYNC_HI 5'h06
`define ASRI_IDLE_BITS8 4'ha
`define ASRI_IDLE_BITS9 4'hb

`endif

// ===== core/asri_rx.v
// Purpose: Serial receiver with status flags and AXI4-Lite registers.
// Assumes: Pin inputs synchronous to aclk; one write and one read at once.
// Notes:   Receive flags clear by a status read followed by a data read.
`timescale 1ns/10ps
`include "asri_map.vh"
module asri_rx #(
  parameter ADDR_W = 8,
  parameter DIV_W  = 16
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire              serial_in_pin,
  input  wire              tx_load_pulse,
  input  wire              tx_buf_write_pulse,
  input  wire              tx_shift_empty,
  input  wire              tx_break_idle_busy,
  input  wire              cpu_wait_mode,
  input  wire              cpu_stop_mode,
  output reg               irq_tx_r,
  output reg               irq_rx_r,
  output reg               irq_err_r
);
  localparam ST_HUNT = 1'b0;
  localparam ST_BIT  = 1'b1;

  reg [6:0]        ctrl_r;
  reg              standby_r;
  reg [7:0]        inten_r;
  reg [7:0]        stat_r;
  reg [DIV_W-1:0]  baud_r;
  reg [7:0]        rx_data_r;
  reg              rx_ninth_bit;
  reg              stat_seen_r;
  reg              aw_full_r;
  reg              w_full_r;
  reg [ADDR_W-1:0] awaddr_q;
  reg [31:0]       wdata_q;
  reg [3:0]        wstrb_q;
  reg              rx_st_r;
  reg [4:0]        rt_r;
  reg [3:0]        bit_idx_r;
  reg [2:0]        hist_r;
  reg [1:0]        smp_r;
  reg [8:0]        shift_r;
  reg              noise_acc_r;
  reg              prev_vote_r;
  reg              resynced_r;
  reg [3:0]        idle_cnt_r;
  reg [3:0]        idle_rt_r;
  reg              idle_armed_r;
  reg              idle_hit_r;
  reg              done_r;
  reg              done_frm_r;
  reg              done_noise_r;
  reg [8:0]        done_bits_r;

  wire en      = ctrl_r[`ASRI_CTRL_EN];
  wire len9    = ctrl_r[`ASRI_CTRL_LEN9];
  wire wakeadr = ctrl_r[`ASRI_CTRL_WAKEADR];
  wire idle_count_start_sel    = ctrl_r[`ASRI_CTRL_IDLE_COUNT_START_SEL];
  wire par_en  = ctrl_r[`ASRI_CTRL_PAREN];
  wire par_odd = ctrl_r[`ASRI_CTRL_PARODD];
  wire run     = en & ~cpu_stop_mode;
  wire tick;
  wire [2:0] vsmp = {smp_r, serial_in_pin};
  wire vmaj;
  wire vnoisy;
  wire [3:0] nbits = len9 ? 4'h9 : 4'h8;
  wire [3:0] idle_thr = len9 ? `ASRI_IDLE_BITS9 : `ASRI_IDLE_BITS8;

  asri_tick_gen #(.DIV_W(DIV_W)) u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (run),
    .divisor (baud_r),
    .tick    (tick)
  );

  asri_vote u_vote (
    .smp   (vsmp),
    .major (vmaj),
    .noisy (vnoisy)
  );

  // Bus writes take effect only when both halves are held.
  wire do_wr = aw_full_r & w_full_r & ~s_axi_bvalid;
  wire wr_ok = do_wr & ~cpu_wait_mode;
  wire wr_ctrl  = wr_ok & (awaddr_q == `ASRI_OFF_CTRL) & wstrb_q[0];
  wire wr_inten = wr_ok & (awaddr_q == `ASRI_OFF_INTEN) & wstrb_q[0];
  wire wr_baud  = wr_ok & (awaddr_q == `ASRI_OFF_BAUD);
  wire wr_map   = (awaddr_q == `ASRI_OFF_CTRL) |
                  (awaddr_q == `ASRI_OFF_INTEN) |
                  (awaddr_q == `ASRI_OFF_BAUD);
  wire rd_go  = s_axi_arvalid & s_axi_arready & ~cpu_wait_mode;
  wire rd_st  = rd_go & (s_axi_araddr == `ASRI_OFF_STATUS);
  wire rd_dat = rd_go & (s_axi_araddr == `ASRI_OFF_DATA);
  // Two-step clear guards against losing a flag software never saw.
  wire rx_clr = rd_dat & stat_seen_r;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `ASRI_RESP_OK;
      aw_full_r     <= 1'b0;
      w_full_r      <= 1'b0;
      awaddr_q      <= {ADDR_W{1'b0}};
      wdata_q       <= 32'h0;
      wstrb_q       <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_r     <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_r     <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        aw_full_r    <= 1'b0;
        w_full_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_map && !cpu_wait_mode) ? `ASRI_RESP_OK
                                                   : `ASRI_RESP_ERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `ASRI_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `ASRI_RESP_OK;
      s_axi_rdata   <= 32'h0;
      if (cpu_wait_mode) begin
        s_axi_rresp <= `ASRI_RESP_ERR;
      end else begin
        case (s_axi_araddr)
          `ASRI_OFF_CTRL: begin
            s_axi_rdata <= {25'h0, ctrl_r[6:5], standby_r, ctrl_r[3:0]};
          end
          `ASRI_OFF_INTEN:  s_axi_rdata <= {24'h0, inten_r};
          `ASRI_OFF_STATUS: s_axi_rdata <= {24'h0, stat_r};
          `ASRI_OFF_DATA:   s_axi_rdata <= {23'h0, rx_ninth_bit, rx_data_r};
          `ASRI_OFF_BAUD: begin
            s_axi_rdata <= {{(32-DIV_W){1'b0}}, baud_r};
          end
          default: s_axi_rresp <= `ASRI_RESP_ERR;
        endcase
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Receive sequencer; every step but the standby arm on a control write waits on a sample tick.
  always @(posedge aclk) begin
    if (!aresetn || !en) begin
      rx_st_r      <= ST_HUNT;
      rt_r         <= 5'h0;
      bit_idx_r    <= 4'h0;
      hist_r       <= 3'h0;
      smp_r        <= 2'h0;
      shift_r      <= 9'h0;
      noise_acc_r  <= 1'b0;
      prev_vote_r  <= 1'b0;
      resynced_r   <= 1'b0;
      idle_cnt_r   <= 4'h0;
      idle_rt_r    <= 4'h0;
      idle_armed_r <= 1'b0;
      idle_hit_r   <= 1'b0;
      done_r       <= 1'b0;
      done_frm_r   <= 1'b0;
      done_noise_r <= 1'b0;
      done_bits_r  <= 9'h0;
    end else begin
      done_r     <= 1'b0;
      idle_hit_r <= 1'b0;
      if (wr_ctrl && wdata_q[`ASRI_CTRL_STBY]) begin
        idle_armed_r <= 1'b1;
      end
      if (tick) begin
        hist_r <= {hist_r[1:0], serial_in_pin};
        if (idle_armed_r && idle_cnt_r >= idle_thr) begin
          idle_hit_r   <= 1'b1;
          idle_armed_r <= 1'b0;
        end
        case (rx_st_r)
          ST_HUNT: begin
            if (hist_r == 3'h7 && !serial_in_pin) begin
              rx_st_r      <= ST_BIT;
              rt_r         <= 5'h2;
              bit_idx_r    <= 4'h0;
              shift_r      <= 9'h0;
              noise_acc_r  <= 1'b0;
              prev_vote_r  <= 1'b0;
              idle_cnt_r   <= 4'h0;
              idle_rt_r    <= 4'h0;
              idle_armed_r <= 1'b1;
            end else if (serial_in_pin) begin
              idle_rt_r <= idle_rt_r + 4'h1;
              if (idle_rt_r == 4'hf && idle_cnt_r != 4'hf) begin
                idle_cnt_r <= idle_cnt_r + 4'h1;
              end
            end else begin
              idle_rt_r  <= 4'h0;
              idle_cnt_r <= 4'h0;
            end
          end
          ST_BIT: begin
            rt_r <= rt_r + 5'h1;
            if (rt_r == `ASRI_RT_LAST) begin
              rt_r       <= 5'h1;
              bit_idx_r  <= bit_idx_r + 4'h1;
              resynced_r <= 1'b0;
            end
            if (bit_idx_r != 4'h0 && prev_vote_r && !resynced_r &&
                rt_r <= `ASRI_RT_SYNC_HI && hist_r[0] &&
                !serial_in_pin) begin
              rt_r       <= 5'h2;
              resynced_r <= 1'b1;
            end
            if (rt_r == `ASRI_RT_VER_A || rt_r == `ASRI_RT_VER_B ||
                rt_r == `ASRI_RT_DAT_A || rt_r == `ASRI_RT_DAT_B) begin
              smp_r <= {smp_r[0], serial_in_pin};
            end
            if (rt_r == `ASRI_RT_VER_C && bit_idx_r == 4'h0) begin
              if (vmaj) begin
                rx_st_r <= ST_HUNT;
                rt_r    <= 5'h0;
                hist_r  <= 3'h0;
              end else begin
                noise_acc_r <= vnoisy;
              end
            end
            if (rt_r == `ASRI_RT_DAT_C) begin
              if (bit_idx_r == 4'h0) begin
                if (vmaj || vnoisy) begin
                  noise_acc_r <= 1'b1;
                end
              end else begin
                noise_acc_r <= noise_acc_r | vnoisy;
                prev_vote_r <= vmaj;
                if (!idle_count_start_sel) begin
                  idle_cnt_r <= vmaj ? idle_cnt_r + 4'h1 : 4'h0;
                end
              end
              if (bit_idx_r != 4'h0 && bit_idx_r <= nbits) begin
                shift_r[bit_idx_r - 4'h1] <= vmaj;
              end
              if (bit_idx_r == nbits + 4'h1) begin
                rx_st_r      <= ST_HUNT;
                done_r       <= 1'b1;
                done_frm_r   <= ~vmaj;
                done_noise_r <= noise_acc_r | vnoisy;
                done_bits_r  <= shift_r;
                hist_r       <= vmaj ? 3'h7 : 3'h0;
                idle_rt_r    <= 4'h0;
                if (idle_count_start_sel) begin
                  idle_cnt_r <= 4'h0;
                end
              end
            end
          end
          default: rx_st_r <= ST_HUNT;
        endcase
      end
    end
  end

  wire       c_ninth  = len9 ? done_bits_r[8] : done_bits_r[7];
  wire       c_parity = len9 ? ^done_bits_r[8:0] : ^done_bits_r[7:0];
  // Address-mark wake lets the marked character through standby.
  wire wake_mark = done_r & standby_r & wakeadr & c_ninth;
  wire accept    = done_r & (~standby_r | wake_mark);
  wire wake_idle = idle_hit_r & standby_r & ~wakeadr;

  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r       <= `ASRI_CTRL_RST;
      standby_r    <= 1'b0;
      inten_r      <= `ASRI_INTEN_RST;
      baud_r       <= `ASRI_BAUD_RST;
      stat_r       <= 8'hc0;
      rx_data_r    <= 8'h0;
      rx_ninth_bit <= 1'b0;
      stat_seen_r  <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= wdata_q[6:0];
      end
      if (wr_inten) begin
        inten_r <= wdata_q[7:0];
      end
      if (wr_baud) begin
        baud_r <= wdata_q[DIV_W-1:0];
      end
      if (wr_ctrl) begin
        standby_r <= wdata_q[`ASRI_CTRL_STBY];
      end else if (wake_mark || wake_idle) begin
        standby_r <= 1'b0;
      end
      if (rd_st) begin
        stat_seen_r <= 1'b1;
      end else if (rd_dat) begin
        stat_seen_r <= 1'b0;
      end
      if (rx_clr) begin
        stat_r[5:0] <= 6'h0;
      end
      if (tx_buf_write_pulse) begin
        stat_r[`ASRI_ST_TXE]   <= 1'b0;
        stat_r[`ASRI_ST_TDONE] <= 1'b0;
      end
      if (tx_load_pulse || !en) begin
        stat_r[`ASRI_ST_TXE] <= 1'b1;
      end
      if ((tx_shift_empty && stat_r[`ASRI_ST_TXE] &&
           !tx_break_idle_busy) || !en) begin
        stat_r[`ASRI_ST_TDONE] <= 1'b1;
      end
      if (idle_hit_r && !standby_r) begin
        stat_r[`ASRI_ST_IDLE] <= 1'b1;
      end
      if (accept && stat_r[`ASRI_ST_FULL] && !rx_clr) begin
        stat_r[`ASRI_ST_OVR] <= 1'b1;
      end else if (accept) begin
        rx_data_r             <= done_bits_r[7:0];
        rx_ninth_bit          <= c_ninth;
        stat_r[`ASRI_ST_FULL] <= 1'b1;
        stat_r[`ASRI_ST_FRM]  <= done_frm_r;
        stat_r[`ASRI_ST_NOISE] <= done_noise_r;
        stat_r[`ASRI_ST_PAR]  <= par_en & (c_parity ^ par_odd);
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_tx_r  <= 1'b0;
      irq_rx_r  <= 1'b0;
      irq_err_r <= 1'b0;
    end else begin
      irq_tx_r  <= en & |(stat_r[7:6] & inten_r[7:6]);
      irq_rx_r  <= ~standby_r & |(stat_r[5:4] & inten_r[5:4]);
      irq_err_r <= ~standby_r & |(stat_r[3:0] & inten_r[3:0]);
    end
  end
endmodule // asri_rx

// ===== core/asri_tick_gen.v
// Purpose: Sample tick at sixteen times the baud rate.
// Assumes: divisor counts aclk cycles per sample tick, zero acts as one.
// Notes:   Held in reset while run is low so stop mode freezes it.
`timescale 1ns/10ps
module asri_tick_gen #(
  parameter DIV_W = 16
) (
  input  wire             aclk,
  input  wire             aresetn,
  input  wire             run,
  input  wire [DIV_W-1:0] divisor,
  output reg              tick
);
  reg [DIV_W-1:0] cnt_r;

  always @(posedge aclk) begin
    if (!aresetn || !run) begin
      cnt_r <= {DIV_W{1'b0}};
      tick  <= 1'b0;
    end else if (cnt_r == {DIV_W{1'b0}}) begin
      cnt_r <= (divisor == {DIV_W{1'b0}}) ? {DIV_W{1'b0}}
                                          : divisor - 1'b1;
      tick  <= 1'b1;
    end else begin
      cnt_r <= cnt_r - 1'b1;
      tick  <= 1'b0;
    end
  end
endmodule // asri_tick_gen

// ===== core/asri_vote.v
// Purpose: Majority vote and disagreement over three line samples.
// Assumes: Purely combinational.
// Notes:   Also used for start verification, where a majority of 1 fails.
`timescale 1ns/10ps
module asri_vote (
  input  wire [2:0] smp,
  output wire       major,
  output wire       noisy
);
  assign major = (smp[0] & smp[1]) | (smp[0] & smp[2]) | (smp[1] & smp[2]);
  assign noisy = ~((smp == 3'h0) | (smp == 3'h7));
endmodule // asri_vote
